/* logic/phy_rx_decode_tenbase_t.sv */
// 100BASE-TX 5B/4B receive decode and 10BASE-T transmit/receive digital path
// Notes on behaviour
// - Lock code-group alignment on J/K until next frame
// - Translate 5-bit groups to MII nibbles
// - J/K delivered as two 0101 nibbles
// - Valid J/K raises data valid, decode continues
// - T/R or two idles end frame silently
// - Unexpected group in frame flags error, arbitrary data
// - Bad start delimiter gives error, 1110, no valid
// - Invalid groups during data valid raise error
// - Take MAC nibbles at 2.5MHz, serialize, Manchester
// - Manchester halves timed by the 20MHz clock
// - Idle transmitter sends normal link pulses
// - Validate Manchester, detect and correct reversed pair
// - Sample halves at 20MHz, build 4-bit nibbles
// - Deliver 10M receive nibbles at 2.5MHz
// - Valid idle link pulses keep link up
// - Overlong transmit enable flags jabber, stops line
// - Jabber clears only once transmit enable drops
`default_nettype none

module phy_rx_decode_tenbase_t #(
  parameter int NLP_PERIOD = phy_path_pkg::NLP_PERIOD_CYCLES,
  parameter int JABBER_LIMIT = phy_path_pkg::JABBER_CYCLES,
  parameter int LINK_LOSS = phy_path_pkg::LINK_LOSS_CYCLES
) (
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  input  wire logic                  speed100,
  input  wire logic                  cgBit,
  input  wire logic                  cgBitValid,
  input  wire phy_path_pkg::mii_tx_s miiTx,
  input  wire logic                  rxLinePos,
  input  wire logic                  rxLineNeg,
  output var  phy_path_pkg::mii_rx_s miiRx,
  output var  logic                  txClkTick,
  output var  phy_path_pkg::line_s   txLine,
  output var  logic                  jabber,
  output var  logic                  rxPolarityReversed,
  output var  logic                  linkUp10
);

  localparam int NLP_W  = $clog2(NLP_PERIOD + 1);
  localparam int JAB_W  = $clog2(JABBER_LIMIT + 1);
  localparam int LINK_W = $clog2(LINK_LOSS + 1);
  localparam int PH_W   = $clog2(phy_path_pkg::NIBBLE_CYCLES);

  typedef struct packed {
    phy_path_pkg::rx100_state_e rxState;
    logic [9:0]                 shift;
    logic [2:0]                 bitCnt;
    logic                       idleSeen;
    logic                       ssdPend;
    phy_path_pkg::mii_rx_s      miiRx;
    logic [PH_W-1:0]            phase;
    logic                       tick;
    logic [3:0]                 txShift;
    logic                       txActive;
    phy_path_pkg::line_s        txLine;
    logic [NLP_W-1:0]           nlpCnt;
    logic [JAB_W-1:0]           jabCnt;
    logic                       jabber;
    logic [2:0]                 posSync;
    logic [2:0]                 negSync;
    phy_path_pkg::line_s        lineF;
    logic                       rxActive;
    logic                       haveHalf;
    logic                       firstHalf;
    logic [3:0]                 rxBits;
    logic [1:0]                 rxBitCnt;
    logic [3:0]                 rxNib;
    logic                       rxNibValid;
    logic [2:0]                 pulseLen;
    logic                       pulseRawPos;
    logic                       polRev;
    logic [LINK_W-1:0]          linkCnt;
    logic                       linkUp;
  } state_s;

  state_s q;
  state_s n;

  // ==========================================================
  // 4B/5B receive translation: {valid, nibble}
  function automatic logic [4:0] decode5b(input logic [4:0] cg);
    logic [4:0] r;
    r = 5'h00;
    unique case (cg)
      5'h1e: r = 5'h10;
      5'h09: r = 5'h11;
      5'h14: r = 5'h12;
      5'h15: r = 5'h13;
      5'h0a: r = 5'h14;
      5'h0b: r = 5'h15;
      5'h0e: r = 5'h16;
      5'h0f: r = 5'h17;
      5'h12: r = 5'h18;
      5'h13: r = 5'h19;
      5'h16: r = 5'h1a;
      5'h17: r = 5'h1b;
      5'h1a: r = 5'h1c;
      5'h1b: r = 5'h1d;
      5'h1c: r = 5'h1e;
      5'h1d: r = 5'h1f;
      default: r = 5'h00;
    endcase
    return r;
  endfunction : decode5b

  function automatic phy_path_pkg::mii_rx_s rxWord(input logic [3:0] d, input logic dv, input logic er,
                                                   input logic crs);
    phy_path_pkg::mii_rx_s w;
    w.data   = d;
    w.dv     = dv;
    w.er     = er;
    w.crs    = crs;
    w.strobe = 1'b1;
    return w;
  endfunction : rxWord

  always_comb begin
    logic [9:0] sh;
    logic       groupDone;
    logic [4:0] dec;
    logic [4:0] grp;
    logic       txBit;
    logic       cp;
    logic       cn;
    logic       act;
    logic       dp;
    sh        = {q.shift[8:0], cgBit};
    groupDone = 1'b0;
    dec       = 5'h00;
    grp       = sh[4:0];
    txBit     = 1'b0;
    cp        = 1'b0;
    cn        = 1'b0;
    act       = 1'b0;
    dp        = q.polRev ? q.negSync[2] : q.posSync[2];
    n = q;
    n.miiRx.strobe = 1'b0;

    // ==========================================================
    // Nibble timing shared by transmit and 10M receive delivery
    n.phase = q.phase + 1'b1;
    n.tick  = (q.phase == PH_W'(phy_path_pkg::NIBBLE_CYCLES - 2));

    // ==========================================================
    // 100M receive decode
    if (speed100) begin
      if (q.ssdPend) begin
        n.ssdPend = 1'b0;
        n.miiRx   = rxWord(phy_path_pkg::SSD_NIBBLE, 1'b1, 1'b0, 1'b1);
      end
      if (cgBitValid) begin
        n.shift   = sh;
        groupDone = (q.bitCnt == 3'(phy_path_pkg::CG_BITS - 1));
        n.bitCnt  = groupDone ? 3'h0 : q.bitCnt + 3'h1;
        dec       = decode5b(grp);
        unique case (q.rxState)
          phy_path_pkg::RX_IDLE: begin
            if (grp == phy_path_pkg::CG_SSD_J) begin
              n.rxState   = phy_path_pkg::RX_CHKK;
              n.bitCnt    = 3'h0;
              n.miiRx.crs = 1'b1;
            end
          end
          phy_path_pkg::RX_CHKK: begin
            if (groupDone) begin
              if (grp == phy_path_pkg::CG_SSD_K) begin
                n.rxState  = phy_path_pkg::RX_FRAME;
                n.idleSeen = 1'b0;
                n.ssdPend  = 1'b1;
                n.miiRx    = rxWord(phy_path_pkg::SSD_NIBBLE, 1'b1, 1'b0, 1'b1);
              end else begin
                n.rxState = phy_path_pkg::RX_IDLE;
                n.miiRx   = rxWord(phy_path_pkg::BAD_SSD_NIBBLE, 1'b0, 1'b1, 1'b0);
              end
            end
          end
          phy_path_pkg::RX_FRAME: begin
            if (groupDone) begin
              if (dec[4]) begin
                n.idleSeen = 1'b0;
                n.miiRx    = rxWord(dec[3:0], 1'b1, 1'b0, 1'b1);
              end else if (grp == phy_path_pkg::CG_ESD_T) begin
                n.rxState = phy_path_pkg::RX_ENDR;
              end else if (grp == phy_path_pkg::CG_IDLE && q.idleSeen) begin
                n.rxState = phy_path_pkg::RX_IDLE;
                n.miiRx   = rxWord(4'h0, 1'b0, 1'b0, 1'b0);
              end else if (grp == phy_path_pkg::CG_IDLE) begin
                n.idleSeen = 1'b1;
              end else begin
                n.miiRx = rxWord(phy_path_pkg::ERR_NIBBLE, 1'b1, 1'b1, 1'b1);
              end
            end
          end
          phy_path_pkg::RX_ENDR: begin
            if (groupDone) begin
              if (grp == phy_path_pkg::CG_ESD_R) begin
                n.rxState = phy_path_pkg::RX_IDLE;
                n.miiRx   = rxWord(4'h0, 1'b0, 1'b0, 1'b0);
              end else begin
                n.rxState = phy_path_pkg::RX_FRAME;
                n.miiRx   = rxWord(phy_path_pkg::ERR_NIBBLE, 1'b1, 1'b1, 1'b1);
              end
            end
          end
          default: n.rxState = phy_path_pkg::RX_IDLE;
        endcase
      end
    end else begin
      n.rxState = phy_path_pkg::RX_IDLE;
      n.ssdPend = 1'b0;
    end

    // ==========================================================
    // 10M transmit: nibble load, Manchester halves, link pulses
    if (q.phase == PH_W'(phy_path_pkg::NIBBLE_CYCLES - 1)) begin
      n.txShift  = miiTx.data;
      n.txActive = miiTx.en && !q.jabber && !speed100;
    end
    txBit = q.txShift[q.phase[PH_W-1:1]];
    if (q.txActive) begin
      n.txLine.pos = q.phase[0] ? txBit : !txBit;
      n.txLine.neg = q.phase[0] ? !txBit : txBit;
      n.nlpCnt     = '0;
    end else if (!miiTx.en && !speed100) begin
      n.nlpCnt     = (q.nlpCnt == NLP_W'(NLP_PERIOD - 1)) ? '0 : q.nlpCnt + 1'b1;
      n.txLine.pos = (q.nlpCnt < NLP_W'(phy_path_pkg::NLP_WIDTH_CYCLES));
      n.txLine.neg = 1'b0;
    end else begin
      n.txLine = '0;
    end
    // Jabber only releases on a dropped enable, never on a timeout
    if (miiTx.en) begin
      if (q.jabCnt == JAB_W'(JABBER_LIMIT - 1)) begin
        n.jabber = 1'b1;
      end else begin
        n.jabCnt = q.jabCnt + 1'b1;
      end
      if (q.jabber) begin
        n.txActive = 1'b0;
        n.txLine   = '0;
      end
    end else begin
      n.jabCnt = '0;
      n.jabber = 1'b0;
    end

    // ==========================================================
    // 10M receive: pin synchronisers and filter
    n.posSync = {q.posSync[1:0], rxLinePos};
    n.negSync = {q.negSync[1:0], rxLineNeg};
    if (q.posSync[1] == q.posSync[2]) begin
      n.lineF.pos = q.posSync[2];
    end
    if (q.negSync[1] == q.negSync[2]) begin
      n.lineF.neg = q.negSync[2];
    end
    cp  = q.polRev ? q.lineF.neg : q.lineF.pos;
    cn  = q.polRev ? q.lineF.pos : q.lineF.neg;
    act = cp || cn;

    n.linkCnt = (q.linkCnt == LINK_W'(LINK_LOSS - 1)) ? q.linkCnt : q.linkCnt + 1'b1;
    if (q.linkCnt == LINK_W'(LINK_LOSS - 1)) begin
      n.linkUp = 1'b0;
    end

    if (!q.rxActive) begin
      // Short lone pulse is a link pulse; sustained activity is a frame
      if (act) begin
        n.pulseLen    = (q.pulseLen == 3'h7) ? q.pulseLen : q.pulseLen + 3'h1;
        n.pulseRawPos = q.lineF.pos;
        if (q.pulseLen == 3'(phy_path_pkg::NLP_MAX_PULSE_CYCLES)) begin
          n.rxActive = !speed100;
          n.haveHalf = 1'b0;
          n.rxBitCnt = 2'h0;
        end
      end else begin
        n.pulseLen = 3'h0;
        if (q.pulseLen != 3'h0 && q.pulseLen <= 3'(phy_path_pkg::NLP_MAX_PULSE_CYCLES)) begin
          n.polRev  = !q.pulseRawPos;
          n.linkUp  = 1'b1;
          n.linkCnt = '0;
        end
      end
    end else if (!act) begin
      n.rxActive = 1'b0;
      n.pulseLen = 3'h0;
    end else begin
      n.linkCnt = '0;
      // One-clock halves never pass the pin filter, so pair raw synced levels; equal pairs slip a half
      if (!q.haveHalf || (q.firstHalf == dp)) begin
        n.haveHalf  = 1'b1;
        n.firstHalf = dp;
      end else begin
        n.haveHalf = 1'b0;
        n.rxBits   = {dp, q.rxBits[3:1]};
        n.rxBitCnt = q.rxBitCnt + 2'h1;
        if (q.rxBitCnt == 2'h3) begin
          n.rxNib      = {dp, q.rxBits[3:1]};
          n.rxNibValid = 1'b1;
        end
      end
    end

    // ==========================================================
    // 10M receive delivery on the nibble tick
    if (!speed100 && q.tick) begin
      if (q.rxNibValid) begin
        n.miiRx      = rxWord(q.rxNib, 1'b1, 1'b0, 1'b1);
        n.rxNibValid = (q.rxActive && act && q.haveHalf && q.firstHalf != dp && q.rxBitCnt == 2'h3);
      end else if (!q.rxActive && q.miiRx.dv) begin
        n.miiRx = rxWord(4'h0, 1'b0, 1'b0, 1'b0);
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      q         <= '0;
      q.rxState <= phy_path_pkg::RX_IDLE;
    end else begin
      q <= n;
    end
  end

  assign miiRx              = q.miiRx;
  assign txClkTick          = q.tick;
  assign txLine             = q.txLine;
  assign jabber             = q.jabber;
  assign rxPolarityReversed = q.polRev;
  assign linkUp10           = q.linkUp;

endmodule : phy_rx_decode_tenbase_t

`default_nettype wire

/* logic/phy_path_pkg.sv */
// Shared constants and carrier types for the PHY receive decode and 10BASE-T path
`default_nettype none

package phy_path_pkg;

  // ==========================================================
  // Clock and timing
  localparam int CLK_HZ             = 20_000_000;
  localparam int NIBBLE_RATE_HZ     = 2_500_000;
  localparam int NIBBLE_CYCLES      = CLK_HZ / NIBBLE_RATE_HZ;
  localparam int NLP_PERIOD_MS      = 16;
  localparam int NLP_PERIOD_CYCLES  = NLP_PERIOD_MS * (CLK_HZ / 1000);
  localparam int NLP_WIDTH_NS       = 100;
  localparam int NLP_WIDTH_CYCLES   = (NLP_WIDTH_NS * (CLK_HZ / 1_000_000) / 1000 < 1) ? 1 :
                                      NLP_WIDTH_NS * (CLK_HZ / 1_000_000) / 1000;
  localparam int NLP_MAX_PULSE_NS   = 200;
  localparam int NLP_MAX_PULSE_CYCLES = NLP_MAX_PULSE_NS * (CLK_HZ / 1_000_000) / 1000;
  localparam int JABBER_MS          = 45;
  localparam int JABBER_CYCLES      = JABBER_MS * (CLK_HZ / 1000);
  localparam int LINK_LOSS_MS       = 50;
  localparam int LINK_LOSS_CYCLES   = LINK_LOSS_MS * (CLK_HZ / 1000);

  // ==========================================================
  // Code groups, first received bit in the MSB
  localparam logic [4:0] CG_IDLE    = 5'h1f;
  localparam logic [4:0] CG_SSD_J   = 5'h18;
  localparam logic [4:0] CG_SSD_K   = 5'h11;
  localparam logic [4:0] CG_ESD_T   = 5'h0d;
  localparam logic [4:0] CG_ESD_R   = 5'h07;
  localparam int         CG_BITS    = 5;

  // ==========================================================
  // Nibble values on the receive bus
  localparam logic [3:0] SSD_NIBBLE     = 4'h5;
  localparam logic [3:0] BAD_SSD_NIBBLE = 4'he;
  localparam logic [3:0] ERR_NIBBLE     = 4'h0;

  // ==========================================================
  // Types
  typedef enum logic [3:0] {
    RX_IDLE  = 4'h1,
    RX_CHKK  = 4'h2,
    RX_FRAME = 4'h4,
    RX_ENDR  = 4'h8
  } rx100_state_e;

  typedef struct packed {
    logic [3:0] data;
    logic       dv;
    logic       er;
    logic       crs;
    logic       strobe;
  } mii_rx_s;

  typedef struct packed {
    logic       en;
    logic [3:0] data;
  } mii_tx_s;

  typedef struct packed {
    logic pos;
    logic neg;
  } line_s;

endpackage : phy_path_pkg

`default_nettype wire

/* dv/phy_path_monitor.sv */
// Port-level assertions for the receive decode and 10BASE-T path
`default_nettype none

module phy_path_monitor #(
  parameter int NLP_PERIOD   = 64,
  parameter int JABBER_LIMIT = 100,
  parameter int LINK_LOSS    = 400
) (
  input wire logic                  clk,
  input wire logic                  reset_n,
  input wire logic                  speed100,
  input wire logic                  cgBit,
  input wire logic                  cgBitValid,
  input wire phy_path_pkg::mii_tx_s miiTx,
  input wire logic                  rxLinePos,
  input wire logic                  rxLineNeg,
  input wire phy_path_pkg::mii_rx_s miiRx,
  input wire logic                  txClkTick,
  input wire phy_path_pkg::line_s   txLine,
  input wire logic                  jabber,
  input wire logic                  rxPolarityReversed,
  input wire logic                  linkUp10
);
  // ==========================================================
  // Helper: run length of transmit enable, saturating so the trigger value is hit once
  int enCount_ff;
  int nxtEnCount;

  always_comb begin
    nxtEnCount = miiTx.en ? ((enCount_ff > JABBER_LIMIT + 8) ? enCount_ff : enCount_ff + 1) : 0;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      enCount_ff <= 0;
    end else begin
      enCount_ff <= nxtEnCount;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // ==========================================================
  // Assertions
  chk_tick_spacing: assert property (txClkTick |=> !txClkTick [*7] ##1 txClkTick)
    else $error("nibble tick spacing wrong");
  chk_ssd_first: assert property ($rose(miiRx.dv) && speed100 |-> miiRx.strobe && miiRx.data == phy_path_pkg::SSD_NIBBLE)
    else $error("first start nibble wrong");
  chk_ssd_second: assert property ($rose(miiRx.dv) && speed100 |=> miiRx.strobe && miiRx.dv && miiRx.data == 4'h5)
    else $error("second start nibble missing");
  chk_bad_start: assert property (speed100 && miiRx.strobe && miiRx.er && !miiRx.dv
                                  |-> miiRx.data == phy_path_pkg::BAD_SSD_NIBBLE && !miiRx.crs)
    else $error("bad start word wrong");
  chk_end_quiet: assert property (miiRx.strobe && !miiRx.dv && !miiRx.er |-> !miiRx.crs)
    else $error("carrier kept at frame end");
  chk_er_steady: assert property (speed100 && $stable(speed100) && !miiRx.strobe |-> $stable(miiRx.er))
    else $error("error flag moved between words");
  chk_jab_idle: assert property (jabber && $past(jabber) |-> !txLine.pos && !txLine.neg)
    else $error("line driven during jabber");
  chk_jab_late: assert property (enCount_ff == JABBER_LIMIT + 4 && !speed100 |-> jabber)
    else $error("jabber not flagged in time");
  chk_jab_early: assert property ($rose(jabber) |-> enCount_ff >= JABBER_LIMIT - 4)
    else $error("jabber flagged too early");
  chk_jab_hold: assert property (jabber && miiTx.en |=> jabber)
    else $error("jabber cleared while enable high");
  chk_jab_clear: assert property (jabber && !miiTx.en |=> !jabber)
    else $error("jabber not cleared after enable low");
  chk_line_excl: assert property (!(txLine.pos && txLine.neg))
    else $error("both line polarities driven");
  chk_rx10_tick: assert property (!speed100 && miiRx.strobe |-> $past(txClkTick))
    else $error("10M word off the nibble tick");

  cover property ($rose(miiRx.dv));
  cover property ($rose(jabber));
  cover property ($rose(linkUp10));
  cover property (!speed100 && miiRx.strobe && miiRx.dv);
endmodule : phy_path_monitor

bind phy_rx_decode_tenbase_t phy_path_monitor #(
  .NLP_PERIOD  (NLP_PERIOD),
  .JABBER_LIMIT(JABBER_LIMIT),
  .LINK_LOSS   (LINK_LOSS)
) mon_u (
  .clk(clk), .reset_n(reset_n), .speed100(speed100), .cgBit(cgBit), .cgBitValid(cgBitValid),
  .miiTx(miiTx), .rxLinePos(rxLinePos), .rxLineNeg(rxLineNeg), .miiRx(miiRx), .txClkTick(txClkTick),
  .txLine(txLine), .jabber(jabber), .rxPolarityReversed(rxPolarityReversed), .linkUp10(linkUp10)
);

`default_nettype wire

/* dv/mac_model.sv */
// Transmit side of the switch MAC facing the PHY over MII
`default_nettype none

module mac_model (
  input wire logic                  clk,
  input wire logic                  reset_n,
  input wire logic                  txClkTick,
  input wire logic                  reqEn,
  input wire logic [3:0]            reqData,
  output var phy_path_pkg::mii_tx_s miiTx
);
  // New nibble only at the edge ending a tick cycle, held the full period
  // Data is inverted on each tick while enable is low so stale nibbles are never mistaken for traffic
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      miiTx <= '0;
    end else if (txClkTick) begin
      miiTx.en   <= reqEn;
      miiTx.data <= reqEn ? reqData : ~miiTx.data;
    end
  end
endmodule : mac_model

`default_nettype wire

/* dv/tb_top.sv */
// Self-checking bench for the receive decode and 10BASE-T path
`default_nettype none
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin fails++; $display("ERROR %s exp=%0h got=%0h", nm, (ex), (got)); end end

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int NLP  = 64;
  localparam int JAB  = 100;
  localparam int LOSS = 400;
  localparam logic [4:0] CODE [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
                                       5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
  logic                  clk;
  logic                  reset_n;
  logic                  speed100;
  logic                  cgBit;
  logic                  cgBitValid;
  logic                  rxLinePos;
  logic                  rxLineNeg;
  logic                  reqEn;
  logic [3:0]            reqData;
  phy_path_pkg::mii_tx_s miiTx;
  phy_path_pkg::mii_rx_s miiRx;
  logic                  txClkTick;
  phy_path_pkg::line_s   txLine;
  logic                  jabber;
  logic                  rxPolarityReversed;
  logic                  linkUp10;
  int                    fails;
  int                    check_count;
  int                    n;
  logic [31:0]           rng;
  logic [3:0]            d;
  logic [6:0]            e;
  logic [6:0]            expQ[$];
  int                    words10;
  phy_path_pkg::mii_rx_s lastDv;
  phy_path_pkg::mii_rx_s lastWord;

  phy_rx_decode_tenbase_t #(.NLP_PERIOD(NLP), .JABBER_LIMIT(JAB), .LINK_LOSS(LOSS)) dut_u (
    .clk(clk), .reset_n(reset_n), .speed100(speed100), .cgBit(cgBit), .cgBitValid(cgBitValid),
    .miiTx(miiTx), .rxLinePos(rxLinePos), .rxLineNeg(rxLineNeg), .miiRx(miiRx), .txClkTick(txClkTick),
    .txLine(txLine), .jabber(jabber), .rxPolarityReversed(rxPolarityReversed), .linkUp10(linkUp10)
  );

  mac_model mac_u (
    .clk(clk), .reset_n(reset_n), .txClkTick(txClkTick), .reqEn(reqEn), .reqData(reqData), .miiTx(miiTx)
  );

  // ==========================================================
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs

  // Notes the words a group should yield, then shifts it in MSB first
  task automatic grp(input logic [4:0] g, input int nw, input logic c, input logic [3:0] dd,
                     input logic dv, input logic er);
    repeat (nw) expQ.push_back({c, dd, dv, er});
    for (int i = 4; i >= 0; i--) begin
      cgBit      <= g[i];
      cgBitValid <= 1'b1;
      @(posedge clk);
    end
  endtask : grp

  // One Manchester bit on the receive pins, one clock per half
  task automatic send_bit(input logic b);
    rxLinePos <= ~b;
    rxLineNeg <= b;
    @(posedge clk);
    rxLinePos <= b;
    rxLineNeg <= ~b;
    @(posedge clk);
  endtask : send_bit

  task automatic results();
    $display("Checks %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results

  // ==========================================================
  // Clock, watcher, watchdog
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk) begin
    if (reset_n === 1'b1 && speed100 === 1'b1 && miiRx.strobe === 1'b1) begin
      if (expQ.size() == 0) begin
        `CHK("stray word", 1'b0, 1'b1)
      end else begin
        e = expQ.pop_front();
        if (e[6]) `CHK("rx data", e[5:2], miiRx.data)
        `CHK("rx dv er", e[1:0], {miiRx.dv, miiRx.er})
      end
    end else if (reset_n === 1'b1 && speed100 === 1'b0 && miiRx.strobe === 1'b1) begin
      words10++;
      lastWord = miiRx;
      if (miiRx.dv === 1'b1) lastDv = miiRx;
    end
  end

  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    results();
  end

  // ==========================================================
  // Main sequence
  initial begin
    {reset_n, speed100, cgBit, cgBitValid, rxLinePos, rxLineNeg, reqEn, reqData} = '0;
    speed100 = 1'b1;
    fails = 0;
    check_count = 0;
    rng = 32'h96df_c45a;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    repeat (3) grp(phy_path_pkg::CG_IDLE, 0, 0, 4'h0, 0, 0);
    grp(phy_path_pkg::CG_SSD_J, 0, 0, 4'h0, 0, 0);
    grp(phy_path_pkg::CG_SSD_K, 2, 1, 4'h5, 1, 0);
    for (int i = 0; i < 16; i++) grp(CODE[i], 1, 1, 4'(i), 1, 0);
    for (int i = 0; i < 4; i++) begin
      rng = xs(rng);
      grp(CODE[rng[3:0]], 1, 1, rng[3:0], 1, 0);
    end
    grp(5'h00, 1, 1, 4'h0, 1, 1);
    grp(CODE[3], 1, 1, 4'h3, 1, 0);
    grp(phy_path_pkg::CG_IDLE, 0, 0, 4'h0, 0, 0);
    grp(CODE[9], 1, 1, 4'h9, 1, 0);
    grp(phy_path_pkg::CG_ESD_T, 0, 0, 4'h0, 0, 0);
    grp(phy_path_pkg::CG_ESD_R, 1, 0, 4'h0, 0, 0);
    repeat (2) grp(phy_path_pkg::CG_IDLE, 0, 0, 4'h0, 0, 0);
    grp(phy_path_pkg::CG_SSD_J, 0, 0, 4'h0, 0, 0);
    grp(phy_path_pkg::CG_SSD_K, 2, 1, 4'h5, 1, 0);
    grp(CODE[7], 1, 1, 4'h7, 1, 0);
    grp(phy_path_pkg::CG_IDLE, 0, 0, 4'h0, 0, 0);
    grp(phy_path_pkg::CG_IDLE, 1, 0, 4'h0, 0, 0);
    grp(phy_path_pkg::CG_SSD_J, 0, 0, 4'h0, 0, 0);
    grp(CODE[0], 1, 1, phy_path_pkg::BAD_SSD_NIBBLE, 0, 1);
    repeat (2) grp(phy_path_pkg::CG_IDLE, 0, 0, 4'h0, 0, 0);
    cgBitValid <= 1'b0;
    repeat (4) @(posedge clk);
    `CHK("pending words", 0, expQ.size())
    // 10M: link pulses while idle, then one Manchester nibble
    speed100 <= 1'b0;
    for (n = 0; n < NLP + 20 && txLine.pos !== 1'b1; n++) @(posedge clk);
    @(posedge clk);
    `CHK("pulse hold", 1'b1, txLine.pos)
    @(posedge clk);
    `CHK("pulse end", 1'b0, txLine.pos)
    rng = xs(rng);
    d = rng[3:0] | 4'h1;
    reqEn <= 1'b1;
    reqData <= d;
    for (n = 0; n < 40 && txLine.neg !== 1'b1; n++) @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      `CHK("half one", {~d[i], d[i]}, {txLine.pos, txLine.neg})
      @(posedge clk);
      `CHK("half two", {d[i], ~d[i]}, {txLine.pos, txLine.neg})
      @(posedge clk);
    end
    // Enable held past the limit, then released
    for (n = 0; n < JAB + 60 && jabber !== 1'b1; n++) @(posedge clk);
    `CHK("jabber set", 1'b1, jabber)
    repeat (20) @(posedge clk);
    `CHK("jabber hold", 1'b1, jabber)
    `CHK("jabber line", 2'b00, {txLine.pos, txLine.neg})
    reqEn <= 1'b0;
    for (n = 0; n < 20 && jabber !== 1'b0; n++) @(posedge clk);
    `CHK("jabber clear", 1'b0, jabber)
    // Receive link pulses on each wire, then silence
    rxLineNeg <= 1'b1;
    repeat (3) @(posedge clk);
    rxLineNeg <= 1'b0;
    repeat (12) @(posedge clk);
    `CHK("link up", 1'b1, linkUp10)
    `CHK("reversed", 1'b1, rxPolarityReversed)
    rxLinePos <= 1'b1;
    repeat (3) @(posedge clk);
    rxLinePos <= 1'b0;
    repeat (12) @(posedge clk);
    `CHK("normal", 1'b0, rxPolarityReversed)
    repeat (LOSS + 40) @(posedge clk);
    `CHK("link lost", 1'b0, linkUp10)
    // 10M receive: alternating preamble settles the half pairing, then all-ones nibbles
    for (int i = 0; i < 48; i++) send_bit(i[0] == 1'b0);
    repeat (12) send_bit(1'b1);
    rxLinePos <= 1'b0;
    rxLineNeg <= 1'b0;
    repeat (40) @(posedge clk);
    `CHK("rx10 nibble", 5'h1f, {lastDv.dv, lastDv.data})
    `CHK("rx10 words", 1'b1, words10 >= 12)
    `CHK("rx10 end", 2'b00, {lastWord.dv, lastWord.crs})
    results();
  end
endmodule : tb_top

`default_nettype wire
